// ===== src/gas_cal_defs.vh
// Purpose: Constants for the gas calibration command unit
// Assumes: 16-bit holding words, single-bit coils
// Notes: Offsets are register offsets, not function addresses
`ifndef GAS_CAL_DEFS_VH
`define GAS_CAL_DEFS_VH

// Register spaces on the access port
`define SPACE_COIL 2'h0
`define SPACE_HOLD 2'h1
`define SPACE_INPUT 2'h2

// Coil offsets
`define COIL_AMBIENT_ZERO 6'h02
`define COIL_NITROGEN_ZERO 6'h06
`define COIL_CONFIRM 6'h07

// Holding register offsets
`define HOLD_C2H4_SPAN 6'h01
`define HOLD_C2H4_BASE 6'h02
`define HOLD_CO2_SPAN 6'h05
`define HOLD_CO2_ZERO 6'h06
`define HOLD_KNOWN_REF 6'h10
`define HOLD_INTERVAL 6'h14

// Input register offsets
`define INPUT_C2H4 6'h00
`define INPUT_CO2 6'h01

// Power-up values and the default ambient zero reference
`define DEF_INTERVAL 16'h012c
`define DEF_SPAN 16'h0100
`define DEF_OFFSET 16'h0000
`define AMBIENT_REF 16'h0004

// Fixed-point position of the span factors
`define SPAN_SHIFT 8

// Timing, seconds, nanoseconds and clock cycles
`define SAMPLE_S 16'h0023
`define MEAS_S 16'h0041
`define CLK_PERIOD_NS 20
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)

`endif

// ===== src/second_tick.v
// Purpose: One-cycle enable pulse once per DIV clock cycles
// Assumes: Single clock, synchronous active-high reset
// Notes: Restart realigns the second boundary to a new measurement
`timescale 1ns/10ps
module second_tick #(
  parameter DIV = 50000000
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Control
  input wire restart_in,
  // Enable pulse
  output reg tick_out
);

  reg [31:0] count_r;

  // Free divider, realigned on restart
  always @(posedge clk_in) begin
    if (rst_in || restart_in) begin
      count_r <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (count_r == DIV - 1) begin
      count_r <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      count_r <= count_r + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

endmodule // second_tick

// ===== src/gas_cal_unit.v
// Purpose: Calibration coils, holding words and measurement-mode control
// Assumes: Framing logic presents decoded coil/holding accesses on clk_in
// Notes: Holding words model non-volatile storage and ignore rst_in
//   Coil and holding offsets arrive already stripped of their bases
//   Zero actions use the live scaled value, so the master lets it settle
//
// Summary of operation
// R1 - Periodic mode pumps gas 35 seconds only
// R2 - Interval zero selects continuous measurement
// R3 - Interval 300 restores default periodic mode
// R4 - Coil 6 requests nitrogen zero
// R5 - Coil 2 requests zero at 400ppm
// R6 - Confirm coil 7 triggers the action
// R7 - Completion clears request and confirm coils
// R8 - New zero stored into holding 6
// R9 - Holding 16 gives known reference value
// R10 - Input 1 reports scaled carbon dioxide
// R11 - Holding 1 ethylene span applied
// R12 - Holding 2 ethylene baseline offset writable
// R13 - Holding 5 carbon dioxide span applied
// R14 - Master keeps interval at least 180s
// R15 - Master zeroes only in continuous mode
// R16 - Nonzero interval periodic; zero after measurement
// R17 - Coils bits, holding 16-bit words
// R18 - Holding words survive reset
// R19 - Lone confirm does nothing, clears itself
`timescale 1ns/10ps
`include "gas_cal_defs.vh"
module gas_cal_unit #(
  parameter SECOND_CYCLES = `SECOND_CYCLES
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Register write port
  input wire wr_in,
  input wire [1:0] wr_space_in,
  input wire [5:0] wr_addr_in,
  input wire [15:0] wr_data_in,
  // Register read port
  input wire rd_in,
  input wire [1:0] rd_space_in,
  input wire [5:0] rd_addr_in,
  output reg [15:0] rd_data_out,
  output reg rd_valid_out,
  // Measurement chain
  input wire [15:0] c2h4_raw_in,
  input wire [15:0] co2_raw_in,
  // Status and actuation
  output reg pump_on_out,
  output reg continuous_out,
  output reg sample_strobe_out,
  output reg cal_done_out,
  output reg [15:0] c2h4_reading_out,
  output reg [15:0] co2_reading_out
);

  // Measurement sequencer states
  // Binary codes; continuous doubles as the reset state
  localparam ST_WAIT = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_CONT = 2'h3;

  // Coils
  reg ambient_zero_request_r;
  reg nitrogen_zero_request_r;
  reg action_confirm_r;
  // Holding words, deliberately outside reset
  reg [15:0] ethylene_span_factor_r;
  reg [15:0] ethylene_baseline_offset_r;
  reg [15:0] carbon_dioxide_span_factor_r;
  reg [15:0] carbon_dioxide_zero_offset_r;
  reg [15:0] known_reference_concentration_r;
  reg [15:0] measurement_interval_seconds_r;
  // Sequencer
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] sec_r;
  reg restart_r;
  wire tick;

  // Power-up contents of the non-volatile words
  // Stands in for the stored image that a real part loads at power-up
  // R18 survive reset
  initial begin
    ethylene_span_factor_r = `DEF_SPAN;
    ethylene_baseline_offset_r = `DEF_OFFSET;
    carbon_dioxide_span_factor_r = `DEF_SPAN;
    carbon_dioxide_zero_offset_r = `DEF_OFFSET;
    known_reference_concentration_r = `DEF_OFFSET;
    measurement_interval_seconds_r = `DEF_INTERVAL;
  end

  // One shared divider; restart puts window edges on whole seconds
  // Limitation: the second in progress at a restart is cut short
  second_tick #(
    .DIV(SECOND_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .restart_in(restart_r),
    .tick_out(tick)
  );

  // Carbon dioxide scaling: raw times span, fixed point
  // Full product kept so a large span cannot wrap before the shift
  wire [31:0] co2_prod = {16'h0000, co2_raw_in} * {16'h0000, carbon_dioxide_span_factor_r};
  wire [15:0] co2_scaled = co2_prod[`SPAN_SHIFT + 15:`SPAN_SHIFT];
  // R13 span applied
  wire [15:0] co2_value = co2_scaled - carbon_dioxide_zero_offset_r;

  // Ethylene reading falls as span rises; zero span guarded
  // Combinational divider: slow refreshes allow it, at a cost in area
  wire [23:0] c2h4_num = {c2h4_raw_in, 8'h00};
  wire [23:0] c2h4_quot = (ethylene_span_factor_r == 16'h0000) ? 24'h00_0000 :
                          c2h4_num / {8'h00, ethylene_span_factor_r};
  // R11 R12 span and baseline
  wire [15:0] c2h4_value = c2h4_quot[15:0] - ethylene_baseline_offset_r;

  // Reference of the pending zero action
  // R5 R9 reference select
  wire [15:0] ambient_ref = (known_reference_concentration_r != 16'h0000) ?
                            known_reference_concentration_r : `AMBIENT_REF;
  // Both pending: nitrogen wins, the stricter reference
  // R4 nitrogen means zero
  wire [15:0] zero_ref = nitrogen_zero_request_r ? 16'h0000 : ambient_ref;
  wire request_pending = ambient_zero_request_r | nitrogen_zero_request_r;
  wire coil_wr = wr_in && (wr_space_in == `SPACE_COIL);
  wire hold_wr = wr_in && (wr_space_in == `SPACE_HOLD);
  // Refresh points: each second in continuous, at window end otherwise
  // R1 R10 refresh points
  wire refresh = tick && ((state_r == ST_CONT) ||
                 (state_r == ST_SAMPLE && state_nxt == ST_SETTLE));

  // Coils: hardware clears on confirm, a master write that cycle wins
  always @(posedge clk_in) begin
    if (rst_in) begin
      ambient_zero_request_r <= 1'b0;
      nitrogen_zero_request_r <= 1'b0;
      action_confirm_r <= 1'b0;
      cal_done_out <= 1'b0;
    end else begin
      cal_done_out <= 1'b0;
      if (action_confirm_r) begin
        // R7 R19 self clear
        ambient_zero_request_r <= 1'b0;
        nitrogen_zero_request_r <= 1'b0;
        action_confirm_r <= 1'b0;
        // No pulse for a lone confirm
        cal_done_out <= request_pending;
      end
      // Written after the clear, so a master write wins
      // R17 R4 R5 coil writes
      if (coil_wr && wr_addr_in == `COIL_AMBIENT_ZERO) begin
        ambient_zero_request_r <= wr_data_in[0];
      end
      if (coil_wr && wr_addr_in == `COIL_NITROGEN_ZERO) begin
        nitrogen_zero_request_r <= wr_data_in[0];
      end
      if (coil_wr && wr_addr_in == `COIL_CONFIRM) begin
        action_confirm_r <= wr_data_in[0];
      end
    end
  end

  // Holding words; zero action writes the offset, master write wins
  always @(posedge clk_in) begin
    // R6 R8 store new zero
    if (action_confirm_r && request_pending) begin
      carbon_dioxide_zero_offset_r <= co2_scaled - zero_ref;
    end
    if (hold_wr) begin
      case (wr_addr_in)
        // R11 ethylene span word
        `HOLD_C2H4_SPAN: ethylene_span_factor_r <= wr_data_in;
        // R12 baseline word
        `HOLD_C2H4_BASE: ethylene_baseline_offset_r <= wr_data_in;
        // R13 span word
        `HOLD_CO2_SPAN: carbon_dioxide_span_factor_r <= wr_data_in;
        // R8 master may restore a saved zero
        `HOLD_CO2_ZERO: carbon_dioxide_zero_offset_r <= wr_data_in;
        // R9 reference word
        `HOLD_KNOWN_REF: known_reference_concentration_r <= wr_data_in;
        // R2 R3 R16 interval word
        `HOLD_INTERVAL: measurement_interval_seconds_r <= wr_data_in;
        default: ;
      endcase
    end
  end

  // Periodic measurement, in seconds from its start:
  //   0 to 34, sample window with the pump drawing gas
  //   35 to 64, pump stopped while the measurement settles
  //   65 onward, idle until the interval has elapsed
  // Intervals under 66 s start the next measurement at 66 s
  // Sequencer next state; a measurement always runs to its end
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT: begin
        // Interval counts from measurement start
        // R2 R16 continuous when zero
        if (measurement_interval_seconds_r == 16'h0000) begin
          state_nxt = ST_CONT;
        end else if (tick && sec_r + 16'h0001 >= measurement_interval_seconds_r) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // R1 sampling window
        if (tick && sec_r + 16'h0001 >= `SAMPLE_S) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // R16 finish measurement first
        if (tick && sec_r + 16'h0001 >= `MEAS_S) begin
          state_nxt = (measurement_interval_seconds_r == 16'h0000) ? ST_CONT : ST_WAIT;
        end
      end
      ST_CONT: begin
        // R3 R16 back to periodic
        if (measurement_interval_seconds_r != 16'h0000) begin
          state_nxt = ST_SAMPLE;
        end
      end
      default: state_nxt = ST_WAIT;
    endcase
  end

  // Sequencer registers; sec_r counts seconds since measurement start
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_CONT;
      sec_r <= 16'h0000;
      restart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      restart_r <= 1'b0;
      // R1 window start; the divider restarts a cycle later,
      // so a tick left from the old second is not counted;
      // sec_r saturates so a huge interval never wraps
      if (state_nxt == ST_SAMPLE && state_r != ST_SAMPLE) begin
        sec_r <= 16'h0000;
        restart_r <= 1'b1;
      end else if (tick && !restart_r && sec_r != 16'hffff) begin
        sec_r <= sec_r + 16'h0001;
      end
    end
  end

  // Actuation and readings, all registered
  always @(posedge clk_in) begin
    if (rst_in) begin
      pump_on_out <= 1'b0;
      continuous_out <= 1'b0;
      sample_strobe_out <= 1'b0;
      c2h4_reading_out <= 16'h0000;
      co2_reading_out <= 16'h0000;
    end else begin
      // R1 pump only in window or in continuous mode
      pump_on_out <= (state_nxt == ST_SAMPLE) || (state_nxt == ST_CONT);
      continuous_out <= (state_nxt == ST_CONT);
      // Readings take the raw inputs only at a refresh point
      sample_strobe_out <= refresh;
      if (refresh) begin
        c2h4_reading_out <= c2h4_value;
        // R10 reported reading
        co2_reading_out <= co2_value;
      end
    end
  end

  // Read port: one-cycle latency, unmapped offsets read zero
  always @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_in;
      rd_data_out <= 16'h0000;
      if (rd_in) begin
        case ({rd_space_in, rd_addr_in})
          // R6 R7 coils read back
          {`SPACE_COIL, `COIL_AMBIENT_ZERO}: rd_data_out <= {15'h0000, ambient_zero_request_r};
          {`SPACE_COIL, `COIL_NITROGEN_ZERO}: rd_data_out <= {15'h0000, nitrogen_zero_request_r};
          {`SPACE_COIL, `COIL_CONFIRM}: rd_data_out <= {15'h0000, action_confirm_r};
          // R17 R18 holding words
          {`SPACE_HOLD, `HOLD_C2H4_SPAN}: rd_data_out <= ethylene_span_factor_r;
          {`SPACE_HOLD, `HOLD_C2H4_BASE}: rd_data_out <= ethylene_baseline_offset_r;
          {`SPACE_HOLD, `HOLD_CO2_SPAN}: rd_data_out <= carbon_dioxide_span_factor_r;
          {`SPACE_HOLD, `HOLD_CO2_ZERO}: rd_data_out <= carbon_dioxide_zero_offset_r;
          {`SPACE_HOLD, `HOLD_KNOWN_REF}: rd_data_out <= known_reference_concentration_r;
          {`SPACE_HOLD, `HOLD_INTERVAL}: rd_data_out <= measurement_interval_seconds_r;
          // R11 input register 0
          {`SPACE_INPUT, `INPUT_C2H4}: rd_data_out <= c2h4_reading_out;
          // R10 input register 1
          {`SPACE_INPUT, `INPUT_CO2}: rd_data_out <= co2_reading_out;
          default: rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

endmodule // gas_cal_unit

// ===== tb/gas_cal_unit_monitor.sv
// Purpose: Port checker for the calibration unit
// Assumes: One clock, sync active-high reset
// Notes: Pump run length kept in a helper counter
`timescale 1ns/10ps
module gas_cal_unit_monitor #(
  parameter SECOND_CYCLES = 10
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Access port
  input wire wr_in,
  input wire [1:0] wr_space_in,
  input wire [5:0] wr_addr_in,
  input wire [15:0] wr_data_in,
  input wire rd_in,
  input wire [15:0] rd_data_out,
  input wire rd_valid_out,
  // Status
  input wire pump_on_out,
  input wire continuous_out,
  input wire sample_strobe_out,
  input wire cal_done_out,
  input wire [15:0] co2_reading_out
);
  localparam int SAMPLE_MAX = 35 * SECOND_CYCLES + 2; // Slack for tick alignment
  reg [31:0] run_r;
  // Periodic pump run length
  always @(posedge clk_in) begin
    if (rst_in || !pump_on_out || continuous_out)
      run_r <= 32'h0;
    else
      run_r <= run_r + 32'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rd_ans; rd_in |=> rd_valid_out; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle; !rd_in |=> !rd_valid_out && rd_data_out == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read answer");
  property p_cont_pump; continuous_out |-> pump_on_out; endproperty
  a_cont_pump: assert property (p_cont_pump) else $error("continuous without pump");
  property p_done_once; cal_done_out |=> !cal_done_out; endproperty
  a_done_once: assert property (p_done_once) else $error("done pulse too long");
  property p_sample_len; run_r <= SAMPLE_MAX; endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample window too long");
  property p_restart;
    wr_in && wr_space_in == 2'h1 && wr_addr_in == 6'h14 && wr_data_in != 16'h0 && continuous_out
      |-> ##[1:3] !continuous_out && pump_on_out;
  endproperty
  a_restart: assert property (p_restart) else $error("periodic mode not entered");
  property p_stb_once; sample_strobe_out |=> !sample_strobe_out; endproperty
  a_stb_once: assert property (p_stb_once) else $error("strobe too long");
  property p_hold_rd; !sample_strobe_out |-> $stable(co2_reading_out); endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("reading moved off strobe");
  // Main scenarios reached
  c_done: cover property (cal_done_out);
  c_cont: cover property ($rose(continuous_out));
  c_stop: cover property ($fell(pump_on_out));
endmodule // gas_cal_unit_monitor
bind gas_cal_unit gas_cal_unit_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) mon (.clk_in(clk_in), .rst_in(rst_in),
  .wr_in(wr_in), .wr_space_in(wr_space_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .pump_on_out(pump_on_out),
  .continuous_out(continuous_out), .sample_strobe_out(sample_strobe_out), .cal_done_out(cal_done_out),
  .co2_reading_out(co2_reading_out));

// ===== tb/modbus_master_model.sv
// Purpose: Register master for the calibration unit
// Assumes: Requests launched 1 ns after a rising edge
// Notes: Released data (after a write) and address (after a read) lines are inverted so stale values never pass
`timescale 1ns/10ps
module modbus_master_model (
  // Clock and answer
  input wire clk_in,
  input wire [15:0] rd_data_in,
  input wire rd_valid_in,
  // Requests, space and offset shared by both strobes
  output reg wr_out = 1'b0,
  output reg rd_out = 1'b0,
  output reg [1:0] sp_out = 2'h0,
  output reg [5:0] ad_out = 6'h0,
  output reg [15:0] wd_out = 16'h0
);
  // One word or coil bit per strobe
  task wr(input [1:0] s, input [5:0] a, input [15:0] d);
    begin
      @(posedge clk_in) #1;
      wr_out = 1'b1;
      sp_out = s;
      ad_out = a;
      wd_out = d;
      @(posedge clk_in) #1;
      wr_out = 1'b0;
      wd_out = ~d;
    end
  endtask
  // Answer stands the cycle after the taking edge
  task rd(input [1:0] s, input [5:0] a, output [15:0] d);
    begin
      @(posedge clk_in) #1;
      rd_out = 1'b1;
      sp_out = s;
      ad_out = a;
      @(posedge clk_in) #1;
      rd_out = 1'b0;
      ad_out = ~a;
      d = rd_valid_in ? rd_data_in : 16'hxxxx;
    end
  endtask
  task zero_seq(input [5:0] c, input [15:0] r, input k);
    begin
      wr(2'h0, c, 16'h1);
      if (k)
        wr(2'h1, 6'h10, r);
      wr(2'h0, 6'h07, 16'h1);
    end
  endtask
endmodule // modbus_master_model

// ===== tb/gas_calibration_command_unit_bench.sv
// Purpose: Self-checking bench for the calibration unit
// Assumes: One second shortened to 10 clocks
// Notes: hm mirrors holding words; expectations derive from it
`timescale 1ns/10ps
module gas_calibration_command_unit_bench;
  localparam SC = 10;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [15:0] c2h4_raw = 16'h0;
  reg [15:0] co2_raw = 16'h0;
  reg done_seen = 1'b0;
  reg [15:0] v, rf, ev;
  wire wr, rd, rv, pump, cont, stb, done;
  wire [1:0] spc;
  wire [5:0] ad;
  wire [15:0] wd, rdat, c2h4_rd, co2_rd;
  integer failures = 0;
  integer compares = 0;
  integer seed = 32'hfc6e54df;
  integer hm [0:63];
  integer i, t;
  // 50 MHz clock
  always #10 clk_in = ~clk_in;
  // Latch the one-cycle completion pulse
  always @(posedge clk_in) if (done) done_seen <= 1'b1;
  gas_cal_unit #(.SECOND_CYCLES(SC)) DUT (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr), .wr_space_in(spc),
    .wr_addr_in(ad), .wr_data_in(wd), .rd_in(rd), .rd_space_in(spc), .rd_addr_in(ad), .rd_data_out(rdat),
    .rd_valid_out(rv), .c2h4_raw_in(c2h4_raw), .co2_raw_in(co2_raw), .pump_on_out(pump),
    .continuous_out(cont), .sample_strobe_out(stb), .cal_done_out(done), .c2h4_reading_out(c2h4_rd),
    .co2_reading_out(co2_rd));
  modbus_master_model MST (.clk_in(clk_in), .rd_data_in(rdat), .rd_valid_in(rv), .wr_out(wr), .rd_out(rd),
    .sp_out(spc), .ad_out(ad), .wd_out(wd));
  task chk(input [8*8:1] what, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  // Writes keep the holding mirror current
  task w(input [1:0] s, input [5:0] a, input [15:0] d);
    begin
      MST.wr(s, a, d);
      if (s == 2'h1)
        hm[a] = d;
    end
  endtask
  task rchk(input [1:0] s, input [5:0] a, input [15:0] e);
    begin
      MST.rd(s, a, v);
      chk("read", e, v);
    end
  endtask
  // Bounded wait for strobe (k=0) or continuous mode (k=1)
  task wait_hi(input integer k, input integer lim);
    integer n;
    begin
      @(posedge clk_in) #1;
      for (n = 0; n < lim && (k ? cont : stb) !== 1'b1; n = n + 1)
        @(posedge clk_in) #1;
      if (n == lim) begin
        failures = failures + 1;
        $display("mismatch %0s expected 1 seen 0", k ? "cont" : "strobe");
      end
    end
  endtask
  // Every holding offset, unmapped ones read zero
  task check_all;
    for (i = 0; i < 64; i = i + 1)
      rchk(2'h1, i, hm[i]);
  endtask
  // Kind 0 nitrogen, 1 ambient, 2 known reference
  task zero_case(input integer k);
    begin
      w(2'h1, 6'h05, 16'h0100 + ($random(seed) & 16'hff));
      co2_raw = 16'd100 + ($random(seed) & 16'h3ff);
      rf = (k == 0) ? 16'h0 : (k == 1) ? 16'h4 : 16'h5 + ($random(seed) & 16'hf);
      t = co2_raw * hm[5];
      ev = (t >> 8) - rf;
      done_seen = 1'b0;
      MST.zero_seq(k ? 6'h02 : 6'h06, rf, k == 2);
      if (k == 2)
        hm[16] = rf;
      repeat (4) @(posedge clk_in);
      #1;
      chk("done", 16'h1, {15'h0, done_seen});
      hm[6] = ev;
      rchk(2'h1, 6'h06, ev);
      rchk(2'h0, 6'h07, 16'h0);
      rchk(2'h0, k ? 6'h02 : 6'h06, 16'h0);
      wait_hi(0, 100);
      chk("co2", rf, co2_rd);
      rchk(2'h2, 6'h01, rf);
    end
  endtask
  task final_report;
    begin
      $display("counts compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    failures = failures + 1;
    final_report;
  end
  initial begin
    for (i = 0; i < 64; i = i + 1)
      hm[i] = 0;
    hm[1] = 16'h0100;
    hm[5] = 16'h0100;
    hm[20] = 16'h012c;
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check_all;
    $display("test power_up done");
    wait_hi(0, 1000);
    repeat (2) @(posedge clk_in);
    #1;
    chk("pump", 16'h0, {15'h0, pump});
    chk("cont", 16'h0, {15'h0, cont});
    w(2'h1, 6'h14, 16'h0);
    wait_hi(1, 4000);
    $display("test modes done");
    for (i = 0; i < 3; i = i + 1)
      zero_case(i);
    $display("test zero done");
    done_seen = 1'b0;
    w(2'h0, 6'h07, 16'h1);
    repeat (4) @(posedge clk_in);
    #1;
    chk("done", 16'h0, {15'h0, done_seen});
    rchk(2'h0, 6'h07, 16'h0);
    rchk(2'h1, 6'h06, hm[6]);
    $display("test lone_confirm done");
    w(2'h1, 6'h14, 16'd300);
    repeat (3) @(posedge clk_in);
    #1;
    chk("cont", 16'h0, {15'h0, cont});
    chk("pump", 16'h1, {15'h0, pump});
    w(2'h1, 6'h01, 16'h0040 + ($random(seed) & 16'h1ff));
    w(2'h1, 6'h02, $random(seed));
    c2h4_raw = $random(seed);
    t = {c2h4_raw, 8'h00} / hm[1];
    ev = t - hm[2];
    wait_hi(0, 1000);
    chk("c2h4", ev, c2h4_rd);
    rchk(2'h2, 6'h00, ev);
    $display("test ethylene done");
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check_all;
    $display("test retention done");
    final_report;
  end
endmodule // gas_calibration_command_unit_bench
